// File: rtl/esbi_consts.vh
// Constants for the expansion slot bus interface
`ifndef ESBI_CONSTS_VH
`define ESBI_CONSTS_VH

`define ESBI_CLK_PERIOD_NS  4
`define ESBI_CYC(ns)        ((((ns) + `ESBI_CLK_PERIOD_NS - 1) / `ESBI_CLK_PERIOD_NS))

`define ESBI_ALE_NS         20
`define ESBI_EARLY_NS       40
`define ESBI_CMD_NS         80
`define ESBI_WAIT_STATE_NS  200

`define ESBI_MCLK_MHZ       250
`define ESBI_FAST_MHZ       15
`define ESBI_PROC_MHZ       5
`define ESBI_PROC_INV_PCT   66

`define ESBI_IO_SLOW_LO     16'h0080
`define ESBI_IO_SLOW_HI     16'h00F7

`define ESBI_VEC_PRIO_TWO   8'h52
`define ESBI_VEC_PRIO_THREE 8'h53
`define ESBI_VEC_NMI        8'h02

`define ESBI_SYNC_W         26
`define ESBI_SB_MEM_READY   16
`define ESBI_SB_IO_READY    17
`define ESBI_SB_DMA_A_REQ   18
`define ESBI_SB_DMA_A_TERM  19
`define ESBI_SB_DMA_B_REQ   20
`define ESBI_SB_DMA_B_TERM  21
`define ESBI_SB_IRQ_TWO     22
`define ESBI_SB_IRQ_THREE   23
`define ESBI_SB_NMI         24
`define ESBI_SB_MAN_RESET   25

`endif

// File: rtl/esbi_sync.v
// Two-stage synchroniser for slot inputs
module esbi_sync #(
    parameter W = 26
) (
    input  wire         clk_in,
    input  wire         rst_n_in,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] stage1;

    // Lines idle high through pull-ups
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            stage1   <= {W{1'b1}};
            sync_out <= {W{1'b1}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // esbi_sync

// File: rtl/esbi_clk_gen.v
// Slot clock generators
`include "esbi_consts.vh"
module esbi_clk_gen #(
    parameter MCLK_MHZ = `ESBI_MCLK_MHZ,
    parameter FAST_MHZ = `ESBI_FAST_MHZ,
    parameter PROC_MHZ = `ESBI_PROC_MHZ,
    parameter INV_PCT  = `ESBI_PROC_INV_PCT
) (
    input  wire clk_in,
    input  wire rst_n_in,
    output reg  fast_clock_out,
    output reg  proc_clock_inv_out
);

    localparam [8:0] MOD  = MCLK_MHZ;
    localparam [8:0] INC  = FAST_MHZ;
    localparam [8:0] HALF = MCLK_MHZ / 2;
    localparam [7:0] PER  = MCLK_MHZ / PROC_MHZ;
    localparam [7:0] HIGH = (MCLK_MHZ / PROC_MHZ) * INV_PCT / 100;

    reg [8:0] acc;
    reg [7:0] pcnt;
    wire [8:0] acc_sum = acc + INC;

    // Phase accumulator, average 15 MHz, half high
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            acc            <= 9'h000;
            pcnt           <= 8'h00;
            fast_clock_out <= 1'b0;
            proc_clock_inv_out <= 1'b0;
        end else begin
            acc  <= (acc_sum >= MOD) ? acc_sum - MOD : acc_sum;
            pcnt <= (pcnt == PER - 8'h01) ? 8'h00 : pcnt + 8'h01;
            fast_clock_out     <= (acc < HALF);  // see [RL15]
            proc_clock_inv_out <= (pcnt < HIGH); // see [RL16]
        end
    end

endmodule // esbi_clk_gen

// File: rtl/esbi_slot_bus.v
// System-side expansion slot bus interface
// Functional notes
// [RL1] Data line 0 is least significant, line 15 most significant.
// [RL2] Even-address bytes use lines 0-7, odd-address bytes lines 8-15.
// [RL3] Word at even address moves in one operation on all sixteen lines.
// [RL4] Odd-address word splits: high lane at odd address, then low lane next.
// [RL5] High-byte enable and address bit 0 select word, high, low, none.
// [RL6] Twenty-bit address is latched and held for the whole cycle.
// [RL7] Address is valid at the falling edge of the latch strobe.
// [RL8] Data enable is high only during a data transfer.
// [RL9] Direction is high for writes and low for reads.
// [RL10] Separate active-low read and write commands for memory and I/O.
// [RL11] Early write command goes active before the normal write command.
// [RL12] Ready lines idle high; low inserts wait states, command held.
// [RL13] Ready returning high ends waits and completes the transfer.
// [RL14] System reset output is low on power-on or manual reset.
// [RL15] Fast slot clock at 15 MHz with half duty cycle.
// [RL16] 5 MHz slot clock, inverse of processor clock, 66% high.
// [RL17] Low request line asks for DMA on the matching channel.
// [RL18] Low terminate line ends DMA on that channel.
// [RL19] Priority-two request acknowledged delivers type 52H.
// [RL20] Priority-three request acknowledged delivers type 53H.
// [RL21] Falling edge on non-maskable input delivers type 2.
// [RL22] I/O 80H-F7H gets one automatic wait state; 100H-1FFH none.
// [RL23] Boards decode only memory 40000H-EFFFFH and I/O 80H-1FFH except F8H-FFH.
// [RL24] Byte-wide boards on the low lane at even, high lane at odd.
// [RL25] Boards drive data only when addressed and read is active; the board model drives inverted data otherwise.
// [RL26] Boards sync to the fast clock and treat commands as asynchronous; the board model runs on MCLK_IN instead.
`include "esbi_consts.vh"
module esbi_slot_bus (
    input  wire        MCLK_IN,
    input  wire        RST_N_IN,
    input  wire        MANUAL_RESET_N_IN,
    input  wire        REQ_IN,
    input  wire [19:0] REQ_ADDR_IN,
    input  wire        REQ_IO_IN,
    input  wire        REQ_WRITE_IN,
    input  wire        REQ_WORD_IN,
    input  wire [15:0] REQ_WDATA_IN,
    output reg         BUSY_OUT,
    output reg         DONE_OUT,
    output reg  [15:0] RDATA_OUT,
    output reg  [19:0] SYS_ADDR_OUT,
    output reg         HIGH_BYTE_ENABLE_N_OUT,
    output reg         ADDR_LATCH_OUT,
    output reg         DATA_XFER_ENABLE_OUT,
    output reg         DATA_DIRECTION_OUT,
    output reg         EARLY_MEM_WRITE_N_OUT,
    output reg         MEM_WRITE_N_OUT,
    output reg         EARLY_IO_WRITE_N_OUT,
    output reg         IO_WRITE_N_OUT,
    output reg         MEM_READ_N_OUT,
    output reg         IO_READ_N_OUT,
    input  wire [15:0] SYS_DATA_IN,
    output reg  [15:0] SYS_DATA_OUT,
    output reg         SYS_DATA_OE_N_OUT,
    input  wire        MEM_READY_IN,
    input  wire        IO_READY_IN,
    output reg         SYS_RESET_N_OUT,
    output wire        FAST_CLOCK_OUT,
    output wire        PROC_CLOCK_INV_OUT,
    input  wire        DMA_REQ_CH_A_N_IN,
    input  wire        DMA_TERM_CH_A_N_IN,
    input  wire        DMA_REQ_CH_B_N_IN,
    input  wire        DMA_TERM_CH_B_N_IN,
    input  wire        IRQ_PRIO_TWO_N_IN,
    input  wire        IRQ_PRIO_THREE_N_IN,
    input  wire        NMI_N_IN,
    output reg         DMA_REQ_A_OUT,
    output reg         DMA_TERM_A_OUT,
    output reg         DMA_REQ_B_OUT,
    output reg         DMA_TERM_B_OUT,
    input  wire        INT_ACK_IN,
    output reg         INT_PENDING_OUT,
    output reg  [7:0]  INT_VECTOR_OUT,
    output reg         INT_VECTOR_VALID_OUT,
    output reg         NMI_OUT
);

    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_ADDR  = 3'd1;
    localparam [2:0] ST_EARLY = 3'd2;
    localparam [2:0] ST_CMD   = 3'd3;
    localparam [2:0] ST_WAIT  = 3'd4;
    localparam [2:0] ST_END   = 3'd5;

    localparam [7:0] ALE_CYC   = `ESBI_CYC(`ESBI_ALE_NS);
    localparam [7:0] EARLY_CYC = `ESBI_CYC(`ESBI_EARLY_NS);
    localparam [7:0] CMD_CYC   = `ESBI_CYC(`ESBI_CMD_NS);
    localparam [7:0] WS_CYC    = `ESBI_CYC(`ESBI_WAIT_STATE_NS);

    // Byte from the lane that address bit 0 selects
    function [7:0] lane_pick;
        input       a0;
        input [15:0] d;
        begin
            lane_pick = a0 ? d[15:8] : d[7:0]; // see [RL1] see [RL2]
        end
    endfunction

    // Byte placed on the lane that address bit 0 selects
    function [15:0] lane_place;
        input       a0;
        input [7:0] b;
        begin
            lane_place = a0 ? {b, 8'h00} : {8'h00, b}; // see [RL2]
        end
    endfunction

    wire [`ESBI_SYNC_W-1:0] sync;
    wire [`ESBI_SYNC_W-1:0] raw = {MANUAL_RESET_N_IN, NMI_N_IN, IRQ_PRIO_THREE_N_IN,
                                   IRQ_PRIO_TWO_N_IN, DMA_TERM_CH_B_N_IN, DMA_REQ_CH_B_N_IN,
                                   DMA_TERM_CH_A_N_IN, DMA_REQ_CH_A_N_IN, IO_READY_IN,
                                   MEM_READY_IN, SYS_DATA_IN};

    esbi_sync #(
        .W (`ESBI_SYNC_W)
    ) u_sync (
        .clk_in   (MCLK_IN),
        .rst_n_in (RST_N_IN),
        .async_in (raw),
        .sync_out (sync)
    );

    esbi_clk_gen u_clk (
        .clk_in             (MCLK_IN),
        .rst_n_in           (RST_N_IN),
        .fast_clock_out     (FAST_CLOCK_OUT),
        .proc_clock_inv_out (PROC_CLOCK_INV_OUT)
    );

    reg  [2:0]  state;
    reg  [7:0]  cnt;
    reg  [19:0] r_addr;
    reg         r_io;
    reg         r_wr;
    reg         r_word;
    reg  [15:0] r_wdata;
    reg         second;
    reg  [15:0] rbuf;
    reg         nmi_prev;
    reg  [2:0]  next_state;
    reg  [7:0]  next_cnt;
    reg  [15:0] next_rbuf;

    // Phase address, lanes and write data
    wire        split   = r_word & r_addr[0];                  // see [RL4]
    wire [19:0] ph_addr = second ? r_addr + 20'h00001 : r_addr; // see [RL4]
    wire        ph_a0   = ph_addr[0];
    wire        ph_bhe_n = ~(ph_a0 | (r_word & ~split));       // see [RL5]
    wire [7:0]  ph_byte = (split & second) ? r_wdata[15:8] : r_wdata[7:0];
    wire [15:0] ph_wdata = (r_word & ~split) ? r_wdata : lane_place(ph_a0, ph_byte); // see [RL3]
    wire        io_slow = r_io && (ph_addr[15:0] >= `ESBI_IO_SLOW_LO) &&
                          (ph_addr[15:0] <= `ESBI_IO_SLOW_HI) && (ph_addr[19:16] == 4'h0);
    wire [7:0]  cmd_len = io_slow ? CMD_CYC + WS_CYC : CMD_CYC; // see [RL22]
    wire        ready   = r_io ? sync[`ESBI_SB_IO_READY] : sync[`ESBI_SB_MEM_READY];
    wire        xfer    = (next_state == ST_EARLY) | (next_state == ST_CMD) | (next_state == ST_WAIT);
    wire        cmd_on  = (next_state == ST_CMD) | (next_state == ST_WAIT);
    wire        last    = (state == ST_END) & ~(split & ~second);
    wire        nmi_fall = nmi_prev & ~sync[`ESBI_SB_NMI];

    // Bus cycle sequencing
    always @* begin
        next_state = state;
        next_cnt   = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
        case (state)
            ST_IDLE: begin
                if (REQ_IN) begin
                    next_state = ST_ADDR;
                    next_cnt   = ALE_CYC - 8'h01;
                end
            end
            ST_ADDR: begin
                if (cnt == 8'h00) begin
                    next_state = ST_EARLY; // see [RL7]
                    next_cnt   = EARLY_CYC - 8'h01;
                end
            end
            ST_EARLY: begin
                if (cnt == 8'h00) begin
                    next_state = ST_CMD; // see [RL11]
                    next_cnt   = cmd_len - 8'h01;
                end
            end
            ST_CMD: begin
                if (cnt == 8'h00) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (ready) begin
                    next_state = ST_END; // see [RL12] see [RL13]
                end
            end
            ST_END: begin
                if (split & ~second) begin
                    next_state = ST_ADDR; // see [RL4]
                    next_cnt   = ALE_CYC - 8'h01;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Read data assembly from the synchronised bus
    always @* begin
        next_rbuf = rbuf;
        if (r_word & ~split) begin
            next_rbuf = sync[15:0]; // see [RL3]
        end else if (split & second) begin
            next_rbuf[15:8] = lane_pick(ph_a0, sync[15:0]); // see [RL4]
        end else begin
            next_rbuf[7:0] = lane_pick(ph_a0, sync[15:0]); // see [RL2]
        end
    end

    always @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            state   <= ST_IDLE;
            cnt     <= 8'h00;
            r_addr  <= 20'h00000;
            r_io    <= 1'b0;
            r_wr    <= 1'b0;
            r_word  <= 1'b0;
            r_wdata <= 16'h0000;
            second  <= 1'b0;
            rbuf    <= 16'h0000;
            BUSY_OUT  <= 1'b0;
            DONE_OUT  <= 1'b0;
            RDATA_OUT <= 16'h0000;
            SYS_ADDR_OUT <= 20'h00000;
            HIGH_BYTE_ENABLE_N_OUT <= 1'b1;
            ADDR_LATCH_OUT <= 1'b0;
            DATA_XFER_ENABLE_OUT <= 1'b0;
            DATA_DIRECTION_OUT <= 1'b0;
            EARLY_MEM_WRITE_N_OUT <= 1'b1;
            MEM_WRITE_N_OUT <= 1'b1;
            EARLY_IO_WRITE_N_OUT <= 1'b1;
            IO_WRITE_N_OUT <= 1'b1;
            MEM_READ_N_OUT <= 1'b1;
            IO_READ_N_OUT <= 1'b1;
            SYS_DATA_OUT <= 16'h0000;
            SYS_DATA_OE_N_OUT <= 1'b1;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            if (state == ST_IDLE && REQ_IN) begin
                r_addr  <= REQ_ADDR_IN;
                r_io    <= REQ_IO_IN;
                r_wr    <= REQ_WRITE_IN;
                r_word  <= REQ_WORD_IN;
                r_wdata <= REQ_WDATA_IN;
                second  <= 1'b0;
                rbuf    <= 16'h0000;
            end
            if (state == ST_END) begin
                second <= 1'b1;
                if (!r_wr) begin
                    rbuf <= next_rbuf;
                end
            end
            // Address, lanes and write data held from latch phase on
            if (state == ST_ADDR) begin
                SYS_ADDR_OUT <= ph_addr;                 // see [RL6]
                HIGH_BYTE_ENABLE_N_OUT <= ph_bhe_n;      // see [RL5]
                SYS_DATA_OUT <= ph_wdata;                // see [RL1]
                DATA_DIRECTION_OUT <= r_wr;              // see [RL9]
            end
            ADDR_LATCH_OUT <= (next_state == ST_ADDR);  // see [RL7]
            DATA_XFER_ENABLE_OUT <= xfer;               // see [RL8]
            SYS_DATA_OE_N_OUT <= ~(xfer & r_wr);
            EARLY_MEM_WRITE_N_OUT <= ~(xfer & r_wr & ~r_io);   // see [RL11]
            EARLY_IO_WRITE_N_OUT  <= ~(xfer & r_wr & r_io);    // see [RL11]
            MEM_WRITE_N_OUT <= ~(cmd_on & r_wr & ~r_io);       // see [RL10]
            IO_WRITE_N_OUT  <= ~(cmd_on & r_wr & r_io);        // see [RL10]
            MEM_READ_N_OUT  <= ~(cmd_on & ~r_wr & ~r_io);      // see [RL10]
            IO_READ_N_OUT   <= ~(cmd_on & ~r_wr & r_io);       // see [RL10]
            BUSY_OUT <= (next_state != ST_IDLE);
            DONE_OUT <= last;
            if (last) begin
                RDATA_OUT <= r_wr ? 16'h0000 : next_rbuf;
            end
        end
    end

    // Reset, DMA and interrupt lines
    always @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            SYS_RESET_N_OUT <= 1'b0;
            nmi_prev <= 1'b1;
            DMA_REQ_A_OUT  <= 1'b0;
            DMA_TERM_A_OUT <= 1'b0;
            DMA_REQ_B_OUT  <= 1'b0;
            DMA_TERM_B_OUT <= 1'b0;
            INT_PENDING_OUT <= 1'b0;
            INT_VECTOR_OUT <= 8'h00;
            INT_VECTOR_VALID_OUT <= 1'b0;
            NMI_OUT <= 1'b0;
        end else begin
            SYS_RESET_N_OUT <= sync[`ESBI_SB_MAN_RESET];     // see [RL14]
            nmi_prev <= sync[`ESBI_SB_NMI];
            DMA_REQ_A_OUT  <= ~sync[`ESBI_SB_DMA_A_REQ];     // see [RL17]
            DMA_TERM_A_OUT <= ~sync[`ESBI_SB_DMA_A_TERM];    // see [RL18]
            DMA_REQ_B_OUT  <= ~sync[`ESBI_SB_DMA_B_REQ];     // see [RL17]
            DMA_TERM_B_OUT <= ~sync[`ESBI_SB_DMA_B_TERM];    // see [RL18]
            INT_PENDING_OUT <= ~sync[`ESBI_SB_IRQ_TWO] | ~sync[`ESBI_SB_IRQ_THREE];
            NMI_OUT <= nmi_fall;
            INT_VECTOR_VALID_OUT <= 1'b0;
            if (nmi_fall) begin
                INT_VECTOR_OUT <= `ESBI_VEC_NMI;             // see [RL21]
                INT_VECTOR_VALID_OUT <= 1'b1;
            end else if (INT_ACK_IN && !sync[`ESBI_SB_IRQ_TWO]) begin
                INT_VECTOR_OUT <= `ESBI_VEC_PRIO_TWO;        // see [RL19]
                INT_VECTOR_VALID_OUT <= 1'b1;
            end else if (INT_ACK_IN && !sync[`ESBI_SB_IRQ_THREE]) begin
                INT_VECTOR_OUT <= `ESBI_VEC_PRIO_THREE;      // see [RL20]
                INT_VECTOR_VALID_OUT <= 1'b1;
            end
        end
    end

endmodule // esbi_slot_bus

// File: verif/esbi_board_model.sv
// Expansion board model: byte store in memory and I/O space, ready stretching
module esbi_board_model (
    input  wire         clk_in,
    input  wire  [19:0] addr_in,
    input  wire         hbe_n_in,
    input  wire         ale_in,
    input  wire         mem_rd_n_in,
    input  wire         mem_wr_n_in,
    input  wire         io_rd_n_in,
    input  wire         io_wr_n_in,
    input  wire  [15:0] data_in,
    input  wire         data_oe_n_in,
    input  wire  [15:0] wait_cyc_in,
    output logic [15:0] data_out,
    output wire         mem_ready_out,
    output wire         io_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [int];
    logic [19:0] lat = 20'h00000;
    logic        hbe = 1'b1;
    logic [15:0] cnt = 16'h0000;
    wire mem_sel = lat >= 20'h40000 && lat <= 20'hEFFFF;
    wire io_sel = lat >= 20'h00080 && lat <= 20'h001FF && !(lat >= 20'h000F8 && lat <= 20'h000FF);
    wire mem_cmd = !mem_rd_n_in || !mem_wr_n_in;
    wire io_cmd = !io_rd_n_in || !io_wr_n_in;
    wire rd = (!mem_rd_n_in && mem_sel) || (!io_rd_n_in && io_sel);
    wire wr = (!mem_wr_n_in && mem_sel) || (!io_wr_n_in && io_sel);
    wire [20:0] base = {io_cmd, lat[19:1], 1'b0};
    function automatic logic [7:0] rdb(input int k);
        return mem.exists(k) ? mem[k] : 8'h00;
    endfunction
    // Ready held low for the first wait_cyc_in cycles of a selected command
    assign mem_ready_out = !(mem_sel && mem_cmd && cnt < wait_cyc_in);
    assign io_ready_out = !(io_sel && io_cmd && cnt < wait_cyc_in);
    initial data_out = 16'h0000;
    always @(negedge ale_in) begin
        lat = addr_in;
        hbe = hbe_n_in;
    end
    always @(posedge clk_in) begin
        cnt <= (mem_cmd || io_cmd) ? cnt + 16'h0001 : 16'h0000;
        data_out <= rd ? {rdb(int'(base) + 1), rdb(int'(base))} : ~data_out;
        if (wr && !data_oe_n_in) begin
            if (!lat[0]) mem[int'(base)] = data_in[7:0];
            if (!hbe) mem[int'(base) + 1] = data_in[15:8];
        end
    end
endmodule // esbi_board_model

// File: verif/esbi_slot_bus_properties.sv
// Concurrent checks on the slot bus ports
module esbi_slot_bus_props (
    input wire        MCLK_IN,
    input wire        RST_N_IN,
    input wire        MANUAL_RESET_N_IN,
    input wire        MEM_READY_IN,
    input wire [19:0] SYS_ADDR_OUT,
    input wire        HIGH_BYTE_ENABLE_N_OUT,
    input wire        DATA_XFER_ENABLE_OUT,
    input wire        DATA_DIRECTION_OUT,
    input wire        EARLY_MEM_WRITE_N_OUT,
    input wire        MEM_WRITE_N_OUT,
    input wire        IO_WRITE_N_OUT,
    input wire        MEM_READ_N_OUT,
    input wire        IO_READ_N_OUT,
    input wire        SYS_RESET_N_OUT,
    input wire        DMA_TERM_CH_B_N_IN,
    input wire        DMA_TERM_B_OUT,
    input wire        NMI_N_IN,
    input wire        NMI_OUT,
    input wire [7:0]  INT_VECTOR_OUT,
    input wire        INT_VECTOR_VALID_OUT
);
    logic [15:0] cmd_len;
    wire cmd_low = !(MEM_READ_N_OUT && IO_READ_N_OUT && MEM_WRITE_N_OUT && IO_WRITE_N_OUT);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Cycles the current command has been low
    always @(posedge MCLK_IN) begin
        if (!RST_N_IN || !cmd_low) cmd_len <= 16'h0000;
        else if (cmd_len != 16'hFFFF) cmd_len <= cmd_len + 16'h0001;
    end
    lanes_legal_a: assert property (DATA_XFER_ENABLE_OUT |-> !(HIGH_BYTE_ENABLE_N_OUT && SYS_ADDR_OUT[0]))
        else $error("transfer with no lane selected");
    addr_hold_a: assert property (DATA_XFER_ENABLE_OUT && $past(DATA_XFER_ENABLE_OUT)
        |-> $stable(SYS_ADDR_OUT) && $stable(HIGH_BYTE_ENABLE_N_OUT)) else $error("address moved in transfer");
    read_enable_a: assert property (!MEM_READ_N_OUT || !IO_READ_N_OUT
        |-> DATA_XFER_ENABLE_OUT && !DATA_DIRECTION_OUT) else $error("read without enable or receive");
    write_dir_a: assert property (!MEM_WRITE_N_OUT || !IO_WRITE_N_OUT
        |-> DATA_XFER_ENABLE_OUT && DATA_DIRECTION_OUT) else $error("write without enable or transmit");
    cmd_single_a: assert property ($onehot0({~MEM_READ_N_OUT, ~IO_READ_N_OUT, ~MEM_WRITE_N_OUT, ~IO_WRITE_N_OUT}))
        else $error("two commands at once");
    early_write_a: assert property ($fell(MEM_WRITE_N_OUT) |-> $past(EARLY_MEM_WRITE_N_OUT, 5) == 1'b0)
        else $error("early write not ahead");
    ready_hold_a: assert property (!MEM_READ_N_OUT && !MEM_READY_IN && $past(MEM_READY_IN) == 1'b0
        && $past(MEM_READY_IN, 2) == 1'b0 |=> !MEM_READ_N_OUT) else $error("read ended while not ready");
    ready_end_a: assert property ($rose(MEM_READY_IN) && !MEM_READ_N_OUT |-> ##[1:30] MEM_READ_N_OUT)
        else $error("read not ended after ready");
    io_slow_wait_a: assert property ($fell(cmd_low) && !($past(IO_READ_N_OUT) && $past(IO_WRITE_N_OUT))
        && SYS_ADDR_OUT[19:8] == 12'h000 && SYS_ADDR_OUT[7:0] >= 8'h80 && SYS_ADDR_OUT[7:0] <= 8'hF7
        |-> $past(cmd_len) >= 16'h0040) else $error("slow I/O without wait state");
    man_reset_a: assert property (!MANUAL_RESET_N_IN [*5] |-> !SYS_RESET_N_OUT)
        else $error("system reset not driven");
    dma_term_a: assert property (DMA_TERM_B_OUT != $past(DMA_TERM_CH_B_N_IN, 3))
        else $error("terminate not passed on");
    nmi_type_a: assert property ($fell(NMI_N_IN)
        |-> ##[1:6] (NMI_OUT && INT_VECTOR_VALID_OUT && INT_VECTOR_OUT == 8'h02)) else $error("no type 2 on nmi");
endmodule // esbi_slot_bus_props
bind esbi_slot_bus esbi_slot_bus_props u_props (.*);

// File: verif/esbi_slot_bus_bench.sv
// Self-checking bench for the expansion slot bus interface
`include "esbi_consts.vh"
module esbi_slot_bus_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK_IN = 1'b0, RST_N_IN = 1'b0, MANUAL_RESET_N_IN = 1'b1, REQ_IN = 1'b0, REQ_IO_IN = 1'b0;
    logic REQ_WRITE_IN = 1'b0, REQ_WORD_IN = 1'b0, INT_ACK_IN = 1'b0, NMI_N_IN = 1'b1;
    logic [19:0] REQ_ADDR_IN = 20'h00000;
    logic [15:0] REQ_WDATA_IN = 16'h0000, wait_cyc = 16'h0000;
    logic [3:0] dma_n = 4'hF;
    logic [1:0] irq_n = 2'h3;
    logic [19:0] ioa [6] = '{20'h00080, 20'h000F5, 20'h000A1, 20'h00100, 20'h001FE, 20'h00137};
    logic [1:0] irqs [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    wire BUSY_OUT, DONE_OUT, HIGH_BYTE_ENABLE_N_OUT, ADDR_LATCH_OUT, DATA_XFER_ENABLE_OUT, DATA_DIRECTION_OUT;
    wire EARLY_MEM_WRITE_N_OUT, MEM_WRITE_N_OUT, EARLY_IO_WRITE_N_OUT, IO_WRITE_N_OUT, MEM_READ_N_OUT, IO_READ_N_OUT;
    wire SYS_DATA_OE_N_OUT, MEM_READY_IN, IO_READY_IN, SYS_RESET_N_OUT, FAST_CLOCK_OUT, PROC_CLOCK_INV_OUT;
    wire DMA_REQ_A_OUT, DMA_TERM_A_OUT, DMA_REQ_B_OUT, DMA_TERM_B_OUT, INT_PENDING_OUT, INT_VECTOR_VALID_OUT, NMI_OUT;
    wire [15:0] RDATA_OUT, SYS_DATA_IN, SYS_DATA_OUT;
    wire [19:0] SYS_ADDR_OUT;
    wire [7:0]  INT_VECTOR_OUT;
    logic [7:0]  bm [int];
    logic [15:0] rq [$];
    logic [7:0]  vq [$];
    int err_total = 0, num_checks = 0, cyc = 0, i, hi, fhi, fr;
    logic [19:0] a;
    logic fprev;
    esbi_slot_bus uut (.*, .DMA_REQ_CH_A_N_IN(dma_n[3]), .DMA_TERM_CH_A_N_IN(dma_n[2]), .DMA_REQ_CH_B_N_IN(dma_n[1]),
        .DMA_TERM_CH_B_N_IN(dma_n[0]), .IRQ_PRIO_TWO_N_IN(irq_n[1]), .IRQ_PRIO_THREE_N_IN(irq_n[0]));
    esbi_board_model board (.clk_in(MCLK_IN), .addr_in(SYS_ADDR_OUT), .hbe_n_in(HIGH_BYTE_ENABLE_N_OUT),
        .ale_in(ADDR_LATCH_OUT), .mem_rd_n_in(MEM_READ_N_OUT), .mem_wr_n_in(MEM_WRITE_N_OUT),
        .io_rd_n_in(IO_READ_N_OUT), .io_wr_n_in(IO_WRITE_N_OUT), .data_in(SYS_DATA_OUT),
        .data_oe_n_in(SYS_DATA_OE_N_OUT), .wait_cyc_in(wait_cyc), .data_out(SYS_DATA_IN),
        .mem_ready_out(MEM_READY_IN), .io_ready_out(IO_READY_IN));
    initial begin
        forever #2 MCLK_IN = ~MCLK_IN;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One request; the expected read data goes onto the queue
    task automatic xfer(input logic [19:0] ad, input logic io, input logic wr, input logic wd, input logic [15:0] wv);
        int k;
        k = int'({io, ad});
        if (wr) begin
            bm[k] = wv[7:0];
            if (wd) bm[k + 1] = wv[15:8];
            rq.push_back(16'h0000);
        end else begin
            rq.push_back({wd ? bm[k + 1] : 8'h00, bm[k]});
        end
        while (BUSY_OUT !== 1'b0) @(posedge MCLK_IN) #1;
        {REQ_IN, REQ_ADDR_IN, REQ_IO_IN, REQ_WRITE_IN, REQ_WORD_IN, REQ_WDATA_IN} = {1'b1, ad, io, wr, wd, wv};
        @(posedge MCLK_IN) #1;
        REQ_IN = 1'b0;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge MCLK_IN);
        #1;
    endtask
    always @(posedge MCLK_IN) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            report_and_stop();
        end
    end
    always @(negedge MCLK_IN) begin
        if (DONE_OUT === 1'b1) begin
            if (rq.size() == 0) check("done", 16'h0001, 16'h0000);
            else check("rdata", RDATA_OUT, rq.pop_front());
        end
        if (INT_VECTOR_VALID_OUT === 1'b1) begin
            if (vq.size() == 0) check("vector valid", 16'h0001, 16'h0000);
            else check("vector", {8'h00, INT_VECTOR_OUT}, {8'h00, vq.pop_front()});
        end
    end
    initial begin
        void'($urandom(58));
        cycles(16);
        RST_N_IN = 1'b1;
        for (i = 0; i < 16; i++) begin
            a = 20'h40000 + ($urandom % 20'hAFFFE);
            a[0] = i[1];
            wait_cyc = (i % 4 == 3) ? 16'h003C : 16'h0000;
            xfer(a, 1'b0, 1'b1, i[0], 16'($urandom));
            xfer(a, 1'b0, 1'b0, i[0], 16'h0000);
        end
        $display("memory test done");
        foreach (ioa[j]) begin
            a = ioa[j];
            wait_cyc = (j > 3) ? 16'h005A : 16'h0000;
            xfer(a, 1'b1, 1'b1, j[0], 16'($urandom));
            xfer(a, 1'b1, 1'b0, j[0], 16'h0000);
            xfer(a, 1'b1, 1'b1, ~j[0], 16'($urandom));
            xfer(a, 1'b1, 1'b0, ~j[0], 16'h0000);
        end
        while (rq.size() != 0) cycles(1);
        $display("io test done");
        for (i = 0; i < 8; i++) begin
            dma_n = 4'($urandom);
            cycles(5);
            check("dma", {12'h000, DMA_REQ_A_OUT, DMA_TERM_A_OUT, DMA_REQ_B_OUT, DMA_TERM_B_OUT}, {12'h000, ~dma_n});
        end
        dma_n = 4'hF;
        $display("dma test done");
        foreach (irqs[j]) begin
            irq_n = irqs[j];
            cycles(5);
            check("pending", {15'h0000, INT_PENDING_OUT}, {15'h0000, irq_n != 2'h3});
            if (irq_n != 2'h3) vq.push_back(irq_n[1] ? `ESBI_VEC_PRIO_THREE : `ESBI_VEC_PRIO_TWO);
            INT_ACK_IN = 1'b1;
            cycles(1);
            INT_ACK_IN = 1'b0;
            cycles(3);
            irq_n = 2'h3;
            cycles(5);
        end
        vq.push_back(`ESBI_VEC_NMI);
        NMI_N_IN = 1'b0;
        cycles(8);
        NMI_N_IN = 1'b1;
        cycles(8);
        check("vector queue", 16'(vq.size()), 16'h0000);
        $display("interrupt test done");
        MANUAL_RESET_N_IN = 1'b0;
        cycles(6);
        check("reset out low", {15'h0000, SYS_RESET_N_OUT}, 16'h0000);
        MANUAL_RESET_N_IN = 1'b1;
        cycles(6);
        check("reset out high", {15'h0000, SYS_RESET_N_OUT}, 16'h0001);
        $display("reset test done");
        @(posedge PROC_CLOCK_INV_OUT);
        {hi, fhi, fr, fprev} = {32'h0, 32'h0, 32'h0, FAST_CLOCK_OUT};
        repeat (500) begin
            @(negedge MCLK_IN);
            hi += PROC_CLOCK_INV_OUT;
            fhi += FAST_CLOCK_OUT;
            fr += (FAST_CLOCK_OUT && !fprev);
            fprev = FAST_CLOCK_OUT;
        end
        check("proc clock high", 16'(hi), 16'h014A);
        check("fast clock rate", {15'h0000, fr >= 29 && fr <= 31}, 16'h0001);
        check("fast clock duty", {15'h0000, fhi >= 240 && fhi <= 260}, 16'h0001);
        $display("clock test done");
        report_and_stop();
    end
endmodule // esbi_slot_bus_bench
